// ---- pkg/sbcd_pkg.sv ----
package sbcd_pkg;

  // array geometry: two byte lanes of nine bits each
  localparam int ADDR_W = 21;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int DATA_W = 18;
  localparam int BURST_W = 2;
  localparam int WBUF_DEPTH = 4;

  // reset values
  localparam logic [BURST_W-1:0] RST_COUNT = 2'h0;
  localparam logic [ADDR_W-1:0] RST_BASE = 21'h000000;
  localparam logic [DATA_W-1:0] RST_RDATA = 18'h00000;
  // burst order pin is pulled high, so interleaved order until sampled
  localparam logic [1:0] RST_ORDER = 2'h3;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // kind of the burst in progress, fixed at its begin cycle
  typedef enum logic [1:0] {
    MODE_DESEL,
    MODE_READ,
    MODE_WRITE
  } sbcd_mode_t;

  // one queued array write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] lane_en;
  } sbcd_wr_t;

  localparam int WR_W = $bits(sbcd_wr_t);

  // whole state of the cycle decoder
  typedef struct packed {
    sbcd_mode_t mode;
    logic [ADDR_W-1:0] base;
    logic [BURST_W-1:0] count;
    logic [DATA_W-1:0] rdata;
    logic [1:0] order_sync;
  } sbcd_state_t;

endpackage

// ---- hw/sbcd_top.sv ----
`timescale 1ns/1ps

// small fifo of flip-flops, indexed by wrapping pointers with a lap bit
module sbcd_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PTR_W:0] wr_ptr;
    logic [PTR_W:0] rd_ptr;
  } sbcd_fifo_state_t;

  sbcd_fifo_state_t st;
  sbcd_fifo_state_t next_st;
  logic full;
  logic empty;

  // full when pointers differ only in the lap bit
  always_comb begin
    empty = (st.wr_ptr == st.rd_ptr);
    full = (st.wr_ptr[PTR_W-1:0] == st.rd_ptr[PTR_W-1:0]) && (st.wr_ptr[PTR_W] != st.rd_ptr[PTR_W]);
  end

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = st.mem[st.rd_ptr[PTR_W-1:0]];

  // push and pop may happen in the same cycle
  always_comb begin
    next_st = st;
    if (i_in_valid && !full) begin
      next_st.mem[st.wr_ptr[PTR_W-1:0]] = i_in_data;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (i_out_ready && !empty) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// cycle decoder and burst sequencer of the flow-through burst memory
module sbcd_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic I_CHIP_SELECT_FIRST_N,
  input wire logic I_CHIP_SELECT_SECOND,
  input wire logic I_CHIP_SELECT_THIRD_N,
  input wire logic I_ADVANCE_OR_LOAD,
  input wire logic I_READ_WRITE,
  input wire logic [sbcd_pkg::LANES-1:0] I_BYTE_WRITE_ENABLES_N,
  input wire logic I_CLOCK_ENABLE_N,
  input wire logic I_OUTPUT_ENABLE_N,
  input wire logic I_BURST_ORDER_SELECT,
  input wire logic [sbcd_pkg::ADDR_W-1:0] I_ADDRESS,
  input wire logic [sbcd_pkg::DATA_W-1:0] I_DQ,
  output logic [sbcd_pkg::DATA_W-1:0] O_DQ,
  output logic O_DQ_OE,
  output logic [sbcd_pkg::ADDR_W-1:0] O_ARRAY_RD_ADDR,
  input wire logic [sbcd_pkg::DATA_W-1:0] I_ARRAY_RD_DATA,
  output logic O_ARRAY_WR_VALID,
  output sbcd_pkg::sbcd_wr_t O_ARRAY_WR,
  input wire logic I_ARRAY_WR_READY,
  output logic O_WBUF_READY
);
  import sbcd_pkg::*;

  sbcd_state_t st;
  sbcd_state_t next_st;
  logic selected;
  logic lane_any;
  logic interleave;
  logic push;
  logic write_load;
  logic [ADDR_W-1:0] next_addr;
  sbcd_wr_t wr_entry;
  logic [WR_W-1:0] wr_bits;

  // low address bits of a burst step: xor in interleaved order, add in linear
  function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
                                                   input logic [BURST_W-1:0] cnt,
                                                   input logic inter);
    if (inter) begin
      burst_low = start ^ cnt;
    end else begin
      burst_low = start + cnt;
    end
  endfunction

  // pin decode; only the second stage of the order synchroniser is read
  always_comb begin
    selected = !I_CHIP_SELECT_FIRST_N && I_CHIP_SELECT_SECOND && !I_CHIP_SELECT_THIRD_N;
    lane_any = |(~I_BYTE_WRITE_ENABLES_N);
    interleave = st.order_sync[1];
    // data of a write is taken at its own edge, so the drivers must already be off while it is presented
    write_load = !I_CLOCK_ENABLE_N && !I_ADVANCE_OR_LOAD && selected && !I_READ_WRITE;
  end

  // cycle decode; an inhibited edge keeps everything but the order synchroniser, which still shifts, including the driven read data
  always_comb begin
    next_st = st;
    push = 1'b0;
    next_st.order_sync = {st.order_sync[0], I_BURST_ORDER_SELECT};
    if (!I_CLOCK_ENABLE_N) begin
      if (!I_ADVANCE_OR_LOAD) begin
        if (selected) begin
          next_st.base = I_ADDRESS;
          next_st.count = RST_COUNT;
          if (I_READ_WRITE) begin
            next_st.mode = MODE_READ;
          end else begin
            next_st.mode = MODE_WRITE;
            push = lane_any;
          end
        end else begin
          next_st.mode = MODE_DESEL;
        end
      end else if (st.mode != MODE_DESEL) begin
        // address, select and read-write pins are ignored while advancing
        next_st.count = st.count + BURST_STEP;
        if (st.mode == MODE_WRITE) begin
          push = lane_any;
        end
      end
    end
    next_addr = {next_st.base[ADDR_W-1:BURST_W], burst_low(next_st.base[BURST_W-1:0], next_st.count, interleave)};
    // the array reads combinationally, so the word is caught at the sampling edge
    if (!I_CLOCK_ENABLE_N && next_st.mode == MODE_READ) begin
      next_st.rdata = I_ARRAY_RD_DATA;
    end
  end

  assign O_ARRAY_RD_ADDR = next_addr;

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st.mode <= MODE_DESEL;
      st.base <= RST_BASE;
      st.count <= RST_COUNT;
      st.rdata <= RST_RDATA;
      st.order_sync <= RST_ORDER;
    end else begin
      st <= next_st;
    end
  end

  // output enable gates the drivers without a clock; no drive in a write burst or under a write command
  assign O_DQ_OE = (st.mode == MODE_READ) && !write_load && !I_OUTPUT_ENABLE_N;
  assign O_DQ = st.rdata;

  // write data is taken at the same edge as the command
  always_comb begin
    wr_entry.addr = next_addr;
    wr_entry.data = I_DQ;
    wr_entry.lane_en = ~I_BYTE_WRITE_ENABLES_N;
    wr_bits = wr_entry;
  end

  // the buffer decouples a slow array; a full buffer drops the write and shows it on O_WBUF_READY
  sbcd_fifo #(
    .W(WR_W),
    .DEPTH(WBUF_DEPTH)
  ) u_wbuf (
    .i_clk(I_CORE_CLK),
    .i_resetn(I_RESETN),
    .i_in_valid(push),
    .o_in_ready(O_WBUF_READY),
    .i_in_data(wr_bits),
    .o_out_valid(O_ARRAY_WR_VALID),
    .i_out_ready(I_ARRAY_WR_READY),
    .o_out_data(O_ARRAY_WR)
  );

  property p_deselect;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (!I_CLOCK_ENABLE_N && !I_ADVANCE_OR_LOAD && !selected) ##1 (!I_CLOCK_ENABLE_N && I_ADVANCE_OR_LOAD)
    |=> !O_DQ_OE;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselect cycle left drivers on");

  property p_read_begin;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (!I_CLOCK_ENABLE_N && !I_ADVANCE_OR_LOAD && selected && I_READ_WRITE) ##1 (!I_OUTPUT_ENABLE_N && !write_load)
    |-> O_DQ_OE && (O_DQ == $past(I_ARRAY_RD_DATA)) && ($past(O_ARRAY_RD_ADDR) == $past(I_ADDRESS));
  endproperty
  a_read_begin: assert property (p_read_begin)
    else $error("read begin did not drive the loaded word");

  property p_write_begin;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (!I_CLOCK_ENABLE_N && !I_ADVANCE_OR_LOAD && selected && !I_READ_WRITE)
    |-> (push == lane_any) && (wr_entry.addr == I_ADDRESS) && (wr_entry.data == I_DQ);
  endproperty
  a_write_begin: assert property (p_write_begin)
    else $error("write begin queued wrong entry");

  property p_abort;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (&I_BYTE_WRITE_ENABLES_N) |-> !push;
  endproperty
  a_abort: assert property (p_abort)
    else $error("write with no lane enabled reached the buffer");

  property p_no_drive_write;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (st.mode == MODE_WRITE) |-> !O_DQ_OE;
  endproperty
  a_no_drive_write: assert property (p_no_drive_write)
    else $error("drivers on during write");

  property p_inhibit;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    I_CLOCK_ENABLE_N |-> !push ##1 ($stable(st.mode) && $stable(st.count) && $stable(st.base) && $stable(O_DQ));
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibited edge changed state");

  property p_advance;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (!I_CLOCK_ENABLE_N && I_ADVANCE_OR_LOAD && st.mode != MODE_DESEL)
    |=> (st.count == $past(st.count) + BURST_STEP) && $stable(st.base) && $stable(st.mode);
  endproperty
  a_advance: assert property (p_advance)
    else $error("burst counter did not step");

  property p_linear;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (!interleave && !I_CLOCK_ENABLE_N && I_ADVANCE_OR_LOAD && st.mode != MODE_DESEL)
    |-> O_ARRAY_RD_ADDR[1:0] == st.base[1:0] + st.count + BURST_STEP;
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear burst address wrong");

  property p_oe_async;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    I_OUTPUT_ENABLE_N |-> !O_DQ_OE;
  endproperty
  a_oe_async: assert property (p_oe_async)
    else $error("drivers on with output enable inactive");

  property p_write_turnaround;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    write_load |-> !O_DQ_OE;
  endproperty
  a_write_turnaround: assert property (p_write_turnaround)
    else $error("drivers on while a write command is presented");

  property p_continue_deselect;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (!I_CLOCK_ENABLE_N && I_ADVANCE_OR_LOAD && st.mode == MODE_DESEL)
    |=> (st.mode == MODE_DESEL) && !O_DQ_OE;
  endproperty
  a_continue_deselect: assert property (p_continue_deselect)
    else $error("advance without a burst left deselect");

  property p_read_continue;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (!I_CLOCK_ENABLE_N && I_ADVANCE_OR_LOAD && st.mode == MODE_READ)
    |=> (st.mode == MODE_READ) && (O_DQ == $past(I_ARRAY_RD_DATA));
  endproperty
  a_read_continue: assert property (p_read_continue)
    else $error("read advance did not show the next word");

  property p_write_continue;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (!I_CLOCK_ENABLE_N && I_ADVANCE_OR_LOAD && st.mode == MODE_WRITE)
    |-> (push == lane_any) && (wr_entry.data == I_DQ) && (wr_entry.lane_en == ~I_BYTE_WRITE_ENABLES_N);
  endproperty
  a_write_continue: assert property (p_write_continue)
    else $error("write advance queued wrong entry");

  property p_ignore_pins;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (!I_CLOCK_ENABLE_N && I_ADVANCE_OR_LOAD && st.mode != MODE_DESEL)
    |-> (O_ARRAY_RD_ADDR[ADDR_W-1:BURST_W] == st.base[ADDR_W-1:BURST_W]);
  endproperty
  a_ignore_pins: assert property (p_ignore_pins)
    else $error("advance cycle followed the address pins");

  property p_wrap;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (!I_CLOCK_ENABLE_N && I_ADVANCE_OR_LOAD && st.mode != MODE_DESEL && (&st.count))
    |-> (O_ARRAY_RD_ADDR[BURST_W-1:0] == st.base[BURST_W-1:0]);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("burst did not wrap to its start after four cycles");

  property p_interleaved;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (interleave && !I_CLOCK_ENABLE_N && I_ADVANCE_OR_LOAD && st.mode != MODE_DESEL)
    |-> O_ARRAY_RD_ADDR[1:0] == (st.base[1:0] ^ (st.count + BURST_STEP));
  endproperty
  a_interleaved: assert property (p_interleaved)
    else $error("interleaved burst address wrong");

  property p_inhibit_write;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (I_CLOCK_ENABLE_N && st.mode == MODE_WRITE) |-> (!push && !O_DQ_OE) ##1 (st.mode == MODE_WRITE);
  endproperty
  a_inhibit_write: assert property (p_inhibit_write)
    else $error("inhibited edge during a write wrote or drove");

  property p_power_up;
    @(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (st.mode != MODE_READ) |-> !O_DQ_OE;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("drivers on without a decoded read");

endmodule

// ---- tb/sbcd_array_model.sv ----
`timescale 1ns/1ps

// far-side array: combinational read, write port that stalls at random
module sbcd_array_model (
  input wire logic i_clk,
  input wire logic [sbcd_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [sbcd_pkg::DATA_W-1:0] o_rd_data,
  input wire logic i_wr_valid,
  input wire sbcd_pkg::sbcd_wr_t i_wr,
  output logic o_wr_ready = 1'b0
);
  import sbcd_pkg::*;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic tick = 1'b0;

  // unwritten words hold an address pattern, so a wrong address shows
  function automatic logic [DATA_W-1:0] rd(logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : DATA_W'(a) ^ 18'h15A5A;
  endfunction

  // tick re-evaluates the read after a write to the same word
  always @(i_rd_addr or tick) begin
    o_rd_data = rd(i_rd_addr);
  end

  // lane-masked merge on pop; ready stalls about half the cycles
  always @(posedge i_clk) begin : wr_port
    logic [DATA_W-1:0] w;
    if (i_wr_valid && o_wr_ready) begin
      w = rd(i_wr.addr);
      for (int l = 0; l < LANES; l++) begin
        if (i_wr.lane_en[l]) begin
          w[l*LANE_W +: LANE_W] = i_wr.data[l*LANE_W +: LANE_W];
        end
      end
      mem[i_wr.addr] = w;
      tick = ~tick;
    end
    o_wr_ready <= ($urandom_range(1) == 0);
  end
endmodule

// ---- tb/test_sbcd_top.sv ----
`timescale 1ns/1ps

module test_sbcd_top;
  import sbcd_pkg::*;
  typedef struct packed {
    logic cen_n;
    logic [2:0] sel;
    logic adv;
    logic rw;
    logic [1:0] byte_write_enables_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } sbcd_cmd_t;
  logic I_CORE_CLK = 1'b0;
  logic I_RESETN = 1'b0;
  logic I_BURST_ORDER_SELECT = 1'b1;
  sbcd_cmd_t c = '0;
  sbcd_cmd_t prev = '0;
  logic [DATA_W-1:0] o_dq, dq_bus, rd_data, rdq;
  logic [ADDR_W-1:0] rd_addr, base;
  logic dq_oe, wr_valid, wr_ready, wbuf_rdy;
  sbcd_wr_t wr;
  sbcd_mode_t mode = MODE_DESEL;
  logic [1:0] cnt;
  logic ord = 1'b1;
  logic oe_tied = 1'b0;
  logic [2:0] bad [3] = '{3'b110, 3'b000, 3'b011};
  logic [DATA_W-1:0] emem [logic [ADDR_W-1:0]];
  sbcd_wr_t q[$];
  int num_errors = 0;
  int checks = 0;

  // the wire carries the device's data only while it drives
  assign dq_bus = dq_oe ? o_dq : c.dq;

  sbcd_top dut (.I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN), .I_CHIP_SELECT_FIRST_N(c.sel[2]),
    .I_CHIP_SELECT_SECOND(c.sel[1]), .I_CHIP_SELECT_THIRD_N(c.sel[0]), .I_ADVANCE_OR_LOAD(c.adv),
    .I_READ_WRITE(c.rw), .I_BYTE_WRITE_ENABLES_N(c.byte_write_enables_n), .I_CLOCK_ENABLE_N(c.cen_n),
    .I_OUTPUT_ENABLE_N(c.oe_n), .I_BURST_ORDER_SELECT(I_BURST_ORDER_SELECT), .I_ADDRESS(c.addr),
    .I_DQ(dq_bus), .O_DQ(o_dq), .O_DQ_OE(dq_oe), .O_ARRAY_RD_ADDR(rd_addr), .I_ARRAY_RD_DATA(rd_data),
    .O_ARRAY_WR_VALID(wr_valid), .O_ARRAY_WR(wr), .I_ARRAY_WR_READY(wr_ready), .O_WBUF_READY(wbuf_rdy));
  sbcd_array_model partner (.i_clk(I_CORE_CLK), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
    .i_wr_valid(wr_valid), .i_wr(wr), .o_wr_ready(wr_ready));

  always #10 I_CORE_CLK = ~I_CORE_CLK;

  task automatic cmp_flag(string n, logic e, logic g);
    checks++;
    if (e !== g) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic cmp_vec(string n, logic [WR_W-1:0] e, logic [WR_W-1:0] g);
    checks++;
    if (e !== g) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [DATA_W-1:0] word(logic [ADDR_W-1:0] a);
    return emem.exists(a) ? emem[a] : DATA_W'(a) ^ 18'h15A5A;
  endfunction

  // a write command on the pins turns the drivers off in its own cycle
  function automatic logic wr_load(sbcd_cmd_t k);
    return !k.cen_n && !k.adv && k.sel == 3'b010 && !k.rw;
  endfunction

  function automatic sbcd_cmd_t gen(logic adv, logic [2:0] sel, logic rw);
    sbcd_cmd_t k;
    k.cen_n = 1'b0;
    k.sel = sel;
    k.adv = adv;
    k.rw = rw;
    k.byte_write_enables_n = 2'($urandom_range(3));
    k.oe_n = !oe_tied && ($urandom_range(3) == 0);
    k.addr = ADDR_W'($urandom());
    k.dq = DATA_W'($urandom());
    return k;
  endfunction

  // reference: what the edge that sampled k did to the burst state
  task automatic apply(sbcd_cmd_t k);
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] w;
    if (k.cen_n) return;
    if (!k.adv) begin
      mode = (k.sel != 3'b010) ? MODE_DESEL : (k.rw ? MODE_READ : MODE_WRITE);
      base = k.addr;
      cnt = 2'h0;
    end else if (mode != MODE_DESEL) begin
      cnt = cnt + 2'h1;
    end
    a = {base[ADDR_W-1:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
    if (mode == MODE_READ) rdq = word(a);
    if (mode == MODE_WRITE && k.byte_write_enables_n != 2'h3) begin
      q.push_back({a, k.dq, ~k.byte_write_enables_n});
      w = word(a);
      for (int l = 0; l < LANES; l++) begin
        if (!k.byte_write_enables_n[l]) w[l*LANE_W +: LANE_W] = k.dq[l*LANE_W +: LANE_W];
      end
      emem[a] = w;
    end
  endtask

  // drive k for the next edge; judge the edge that took the previous command
  task automatic op(sbcd_cmd_t k);
    @(posedge I_CORE_CLK);
    c <= k;
    @(negedge I_CORE_CLK);
    apply(prev);
    cmp_flag("dq_oe", mode == MODE_READ && !k.oe_n && !wr_load(k), dq_oe);
    if (mode == MODE_READ) cmp_vec("dq", WR_W'(rdq), WR_W'(o_dq));
    prev = k;
  endtask

  // deselect until every expected write has reached the array
  task automatic drain();
    for (int i = 0; i < 80 && (i < 4 || q.size() > 0 || wr_valid !== 1'b0); i++) op(gen(1'b0, 3'b000, 1'b1));
    cmp_flag("wr_valid", 1'b0, wr_valid);
    cmp_flag("wbuf_ready", 1'b1, wbuf_rdy);
  endtask

  // every entry leaving the buffer must be the next one expected
  always @(posedge I_CORE_CLK) begin
    if (I_RESETN && wr_valid && wr_ready) begin
      cmp_flag("wr_expected", 1'b1, q.size() > 0);
      if (q.size() > 0) cmp_vec("wr_entry", q.pop_front(), wr);
    end
  end

  // bursts of 1 to 7 cycles, with wait states, garbage on ignored pins
  initial begin
    sbcd_cmd_t k;
    logic rw;
    int n;
    void'($urandom(57855));
    repeat (4) @(posedge I_CORE_CLK);
    I_RESETN <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      // the order pin moves only with no burst open, so its synchroniser delay cannot skew a burst
      drain();
      @(posedge I_CORE_CLK);
      ord = (p == 0);
      oe_tied = (p == 1);
      I_BURST_ORDER_SELECT <= ord;
      drain();
      repeat (40) begin
        rw = 1'($urandom_range(1));
        if (rw) drain();
        n = $urandom_range(6);
        for (int j = 0; j <= n; j++) begin
          // wait states keep the buffer from overflowing
          while (q.size() > 2) op(gen(1'b1, 3'b010, 1'b0) | {1'b1, {($bits(k) - 1){1'b0}}});
          k = gen(j > 0, $urandom_range(9) == 0 ? bad[$urandom_range(2)] : 3'b010, rw);
          if (j > 0) k = gen(1'b1, 3'($urandom()), 1'($urandom()));
          k.cen_n = (j > 0 && $urandom_range(4) == 0);
          op(k);
        end
      end
    end
    drain();
    summarize();
  end

  // a run takes far fewer than 20000 cycles
  initial begin
    #400000;
    num_errors++;
    summarize();
  end

  task automatic summarize();
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
endmodule
